// *** inc/dsc_consts.svh ***
// Constants for the daisy-chain serial port: frame layout, counter width and reset values
`ifndef DSC_CONSTS_SVH
`define DSC_CONSTS_SVH

// Frame layout
`define DSC_FRAME_BITS 24
`define DSC_CMD_BITS 8
`define DSC_DATA_BITS 16
`define DSC_CMD_MSB 23
`define DSC_CMD_LSB 16
`define DSC_DATA_MSB 15
`define DSC_DATA_LSB 0

// Bit counter width, holds 0..FRAME_BITS
`define DSC_CNT_BITS 5

// Reset values
`define DSC_CMD_RST 8'h00
`define DSC_DATA_RST 16'h0000
`define DSC_WORD_RST 24'h000000

`endif

// *** inc/dsc_if.sv ***
// Carrier between the port controller and its shift register
`timescale 1ns/1ps
interface dsc_if #(
  parameter int FRAME_BITS = 24,
  parameter int CNT_BITS = 5
);
  logic clear;
  logic shift_en;
  logic din_bit;
  logic [FRAME_BITS-1:0] word;
  logic full;
  logic out_bit;

  modport ctl (
    output clear,
    output shift_en,
    output din_bit,
    input word,
    input full,
    input out_bit
  );

  modport sr (
    input clear,
    input shift_en,
    input din_bit,
    output word,
    output full,
    output out_bit
  );
endinterface

// *** inc/dsc_pkg.sv ***
// Types for the daisy-chain serial port
package dsc_pkg;

  // Port state, one-hot
  typedef enum logic [1:0] {
    DSC_IDLE = 2'b01,
    DSC_SELECT = 2'b10
  } dsc_state_e;

  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] data;
  } dsc_frame_s;

endpackage

// *** rtl/dsc_port.sv ***
// Daisy-chain serial slave port: pin sampling, frame capture, pass-through output
//
// Operation
// - Serial clock and data are ignored unless chip select is held low.
// - A frame is 24 bits: 8 command bits then 16 data bits.
// - Output repeats each input bit 24.5 serial clocks after its falling-edge sample.
// - Serial output is undriven whenever chip select is high.
`timescale 1ns/1ps
`include "dsc_consts.svh"
module dsc_port #(
  parameter int FRAME_BITS = `DSC_FRAME_BITS,
  parameter int CNT_BITS = `DSC_CNT_BITS
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Serial pins from the host
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_din,
  // Serial data out, three-state
  output logic o_dout,
  output logic o_dout_oe,
  // Received frame
  output logic [`DSC_CMD_BITS-1:0] o_cmd,
  output logic [`DSC_DATA_BITS-1:0] o_data,
  output logic o_frame_stb,
  output logic o_short_stb,
  output logic o_busy,
  // Shared open-drain fault line
  input wire logic i_fault,
  output logic o_fault_n_o,
  output logic o_fault_n_oe
);

  dsc_if #(.FRAME_BITS(FRAME_BITS), .CNT_BITS(CNT_BITS)) sr_bus ();

  dsc_shift #(
    .FRAME_BITS(FRAME_BITS),
    .CNT_BITS(CNT_BITS)
  ) u_shift (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .bus(sr_bus.sr)
  );

  // Splits a captured word into command and data fields
  function automatic dsc_pkg::dsc_frame_s split_word(input logic [FRAME_BITS-1:0] w);
    dsc_pkg::dsc_frame_s f;
    f.cmd = w[`DSC_CMD_MSB:`DSC_CMD_LSB];
    f.data = w[`DSC_DATA_MSB:`DSC_DATA_LSB];
    return f;
  endfunction

  // Pin synchronisers
  // Two flops each: the pins are asynchronous to the core clock
  logic cs_n_s1;
  logic cs_n_s2;
  logic sclk_s1;
  logic sclk_s2;
  logic sclk_d;
  logic din_s1;
  logic din_s2;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cs_n_s1 <= 1'b1;
      cs_n_s2 <= 1'b1;
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_d <= 1'b0;
      din_s1 <= 1'b0;
      din_s2 <= 1'b0;
    end else begin
      cs_n_s1 <= i_cs_n;
      cs_n_s2 <= cs_n_s1;
      sclk_s1 <= i_sclk;
      sclk_s2 <= sclk_s1;
      sclk_d <= sclk_s2;
      din_s1 <= i_din;
      din_s2 <= din_s1;
    end
  end

  // Third stage only for edge detection; each clock phase needs 3+ core cycles
  logic sclk_fall;
  logic sclk_rise;
  assign sclk_fall = sclk_d & ~sclk_s2;
  assign sclk_rise = ~sclk_d & sclk_s2;

  // Port state and outputs
  dsc_pkg::dsc_state_e state;
  dsc_pkg::dsc_state_e next_state;
  logic dout;
  logic next_dout;
  logic dout_oe;
  logic next_dout_oe;
  logic [`DSC_CMD_BITS-1:0] cmd;
  logic [`DSC_CMD_BITS-1:0] next_cmd;
  logic [`DSC_DATA_BITS-1:0] data;
  logic [`DSC_DATA_BITS-1:0] next_data;
  logic frame_stb;
  logic next_frame_stb;
  logic short_stb;
  logic next_short_stb;
  logic fault_oe;
  logic next_fault_oe;
  logic fault_o;
  logic next_fault_o;
  logic clear;
  logic shift_en;
  dsc_pkg::dsc_frame_s last_frame;

  assign last_frame = split_word(sr_bus.word);

  always_comb begin
    next_state = state;
    next_dout = dout;
    next_dout_oe = dout_oe;
    next_cmd = cmd;
    next_data = data;
    next_frame_stb = 1'b0;
    next_short_stb = 1'b0;
    clear = 1'b0;
    shift_en = 1'b0;
    // Open drain: pull low while the fault stands, never drive high
    next_fault_oe = i_fault;
    next_fault_o = 1'b0;
    unique case (state)
      dsc_pkg::DSC_IDLE: begin
        next_dout_oe = 1'b0;
        next_dout = 1'b0;
        if (!cs_n_s2) begin
          // Fresh frame: counter restarts so a short burst is caught
          clear = 1'b1;
          next_dout_oe = 1'b1;
          next_state = dsc_pkg::DSC_SELECT;
        end
      end
      dsc_pkg::DSC_SELECT: begin
        if (cs_n_s2) begin
          // Earlier bits went out on the output and are not acted on
          next_dout_oe = 1'b0;
          next_dout = 1'b0;
          next_state = dsc_pkg::DSC_IDLE;
          if (sr_bus.full) begin
            next_cmd = last_frame.cmd;
            next_data = last_frame.data;
            next_frame_stb = 1'b1;
          end else begin
            next_short_stb = 1'b1;
          end
        end else begin
          // Edges count only while selected
          shift_en = sclk_fall;
          // Rising edge half a clock after the 24th later fall
          if (sclk_rise) begin
            next_dout = sr_bus.out_bit;
          end
        end
      end
    endcase
  end

  assign sr_bus.clear = clear;
  assign sr_bus.shift_en = shift_en;
  // Same sync depth as the clock pin, so data lines up with its fall
  assign sr_bus.din_bit = din_s2;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= dsc_pkg::DSC_IDLE;
      dout <= 1'b0;
      dout_oe <= 1'b0;
      cmd <= `DSC_CMD_RST;
      data <= `DSC_DATA_RST;
      frame_stb <= 1'b0;
      short_stb <= 1'b0;
      fault_oe <= 1'b0;
      fault_o <= 1'b0;
    end else begin
      state <= next_state;
      dout <= next_dout;
      dout_oe <= next_dout_oe;
      cmd <= next_cmd;
      data <= next_data;
      frame_stb <= next_frame_stb;
      short_stb <= next_short_stb;
      fault_oe <= next_fault_oe;
      fault_o <= next_fault_o;
    end
  end

  logic busy;
  logic next_busy;

  always_comb begin
    next_busy = (next_state == dsc_pkg::DSC_SELECT);
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      busy <= 1'b0;
    end else begin
      busy <= next_busy;
    end
  end

  assign o_dout = dout;
  assign o_dout_oe = dout_oe;
  assign o_cmd = cmd;
  assign o_data = data;
  assign o_frame_stb = frame_stb;
  assign o_short_stb = short_stb;
  assign o_busy = busy;
  assign o_fault_n_o = fault_o;
  assign o_fault_n_oe = fault_oe;

endmodule

// *** rtl/dsc_shift.sv ***
// Frame shift register with bit counter and delayed pass-through bit
`timescale 1ns/1ps
`include "dsc_consts.svh"
module dsc_shift #(
  parameter int FRAME_BITS = `DSC_FRAME_BITS,
  parameter int CNT_BITS = `DSC_CNT_BITS
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Controller side
  dsc_if.sr bus
);

  localparam logic [CNT_BITS-1:0] FULL_CNT = CNT_BITS'(FRAME_BITS);

  logic [FRAME_BITS-1:0] word;
  logic [FRAME_BITS-1:0] next_word;
  logic [CNT_BITS-1:0] cnt;
  logic [CNT_BITS-1:0] next_cnt;
  logic hold;
  logic next_hold;

  always_comb begin
    next_word = word;
    next_cnt = cnt;
    next_hold = hold;
    if (bus.clear) begin
      next_cnt = '0;
      next_hold = 1'b0;
    end else if (bus.shift_en) begin
      // Bit leaving the top was taken 24 falling edges ago
      next_hold = word[FRAME_BITS-1];
      next_word = {word[FRAME_BITS-2:0], bus.din_bit};
      // Saturates: only the last 24 bits matter at deselect
      if (cnt != FULL_CNT) begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      word <= '0;
      cnt <= '0;
      hold <= 1'b0;
    end else begin
      word <= next_word;
      cnt <= next_cnt;
      hold <= next_hold;
    end
  end

  assign bus.word = word;
  assign bus.full = (cnt == FULL_CNT);
  assign bus.out_bit = hold;

endmodule

// *** testbench/dsc_host.sv ***
// Host master model driving the serial pins of one port
`timescale 1ns/1ps
module dsc_host (
  input wire logic i_core_clk,
  input wire logic i_dout,
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_din
);
  localparam int HALF = 17; // 170 ns period, under 6 MHz even when chained
  logic [71:0] got;
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_din = 1'b0;
  end
  // MSB first, select held over all n bits of the chain
  task automatic frame(input logic sel, input int n, input logic [71:0] v);
    got = '0;
    @(posedge i_core_clk) o_cs_n <= ~sel;
    repeat (6) @(posedge i_core_clk);
    for (int i = n - 1; i >= 0; i--) begin
      o_din <= v[i];
      o_sclk <= 1'b1;
      repeat (HALF) @(posedge i_core_clk);
      got = {got[70:0], i_dout};
      o_sclk <= 1'b0;
      repeat (HALF) @(posedge i_core_clk);
    end
    o_cs_n <= 1'b1;
    o_din <= ~o_din; // Released line must not look stable
    repeat (8) @(posedge i_core_clk);
  endtask
endmodule

// *** testbench/dsc_port_asserts.sv ***
// Assertions on the pins of the daisy-chain serial port
`timescale 1ns/1ps
module dsc_port_asserts (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic o_dout,
  input wire logic o_dout_oe,
  input wire logic [7:0] o_cmd,
  input wire logic [15:0] o_data,
  input wire logic o_frame_stb,
  input wire logic o_short_stb,
  input wire logic o_busy
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  sel_off_a: assert property (i_cs_n [*6] |-> !o_dout_oe && !o_busy)
    else $error("port active while deselected");
  sel_on_a: assert property (!i_cs_n [*6] |-> o_dout_oe && o_busy)
    else $error("port not active while selected");
  dout_quiet_a: assert property (!o_dout_oe |-> !o_dout)
    else $error("serial out moves while undriven");
  stb_cause_a: assert property (o_frame_stb || o_short_stb |-> $past(i_cs_n, 2) && !$past(i_cs_n, 6))
    else $error("strobe without deselect");
  stb_single_a: assert property (o_frame_stb |-> !o_short_stb ##1 !o_frame_stb)
    else $error("bad frame strobe");
  word_hold_a: assert property (!o_frame_stb |-> $stable({o_cmd, o_data}))
    else $error("word changed without frame");
  dout_edge_a: assert property ($changed(o_dout) && o_dout_oe && $past(o_dout_oe) |->
    $past(i_sclk, 2) && $past(i_sclk, 3))
    else $error("serial out moved off a rising clock");
  cover property (o_frame_stb);
  cover property (o_short_stb);
  cover property ($rose(o_dout_oe));
endmodule
bind dsc_port dsc_port_asserts i_asserts (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_cs_n(i_cs_n), .i_sclk(i_sclk),
  .o_dout(o_dout), .o_dout_oe(o_dout_oe), .o_cmd(o_cmd), .o_data(o_data),
  .o_frame_stb(o_frame_stb), .o_short_stb(o_short_stb), .o_busy(o_busy)
);

// *** testbench/dsc_port_bench.sv ***
// Self-checking bench for the daisy-chain serial port
`timescale 1ns/1ps
module dsc_port_bench;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic fault = 1'b0;
  logic cs_n, sclk, din, dout, dout_oe, frame_stb, short_stb, fault_o, fault_oe;
  logic [7:0] cmd;
  logic [15:0] data;
  int err_count = 0;
  int checked = 0;
  int frames = 0;
  int shorts = 0;
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    frames <= frames + int'(frame_stb === 1'b1);
    shorts <= shorts + int'(short_stb === 1'b1);
  end
  dsc_port i_dut (.i_core_clk(core_clk), .i_rst(rst), .i_cs_n(cs_n), .i_sclk(sclk), .i_din(din),
    .o_dout(dout), .o_dout_oe(dout_oe), .o_cmd(cmd), .o_data(data), .o_frame_stb(frame_stb),
    .o_short_stb(short_stb), .o_busy(), .i_fault(fault), .o_fault_n_o(fault_o), .o_fault_n_oe(fault_oe));
  dsc_host i_host (.i_core_clk(core_clk), .i_dout(dout), .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din));
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("errors=%0d checks=%0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic t_single();
    i_host.frame(1'b1, 24, 72'hA51234);
    check({cmd, data}, 24'hA51234);
    check(24'(frames), 24'h1);
  endtask
  task automatic t_chain();
    logic [47:0] v = 48'h5A0F0F3CBEEF;
    i_host.frame(1'b1, 48, 72'(v));
    check({cmd, data}, 24'h3CBEEF);
    check(24'(frames), 24'h2);
    check({1'b0, i_host.got[22:0]}, {1'b0, v[47:25]});
  endtask
  task automatic t_short();
    i_host.frame(1'b1, 10, 72'h2AA);
    check(24'(shorts), 24'h1);
    check({cmd, data}, 24'h3CBEEF);
  endtask
  task automatic t_ignored();
    i_host.frame(1'b0, 24, 72'hC3C3C3);
    check({cmd, data}, 24'h3CBEEF);
    check(24'(frames + shorts), 24'h3);
    check({23'h0, dout_oe}, 24'h0);
    // Word is kept across selections, so early pass-through bits show whether it moved
    i_host.frame(1'b1, 24, 72'h5A0F0F);
    check(i_host.got[23:0], 24'h7DDF55);
    check({cmd, data}, 24'h5A0F0F);
  endtask
  task automatic t_fault();
    @(posedge core_clk) fault <= 1'b1;
    repeat (2) @(posedge core_clk);
    check({22'h0, fault_oe, fault_o}, 24'h2);
    fault <= 1'b0;
    repeat (2) @(posedge core_clk);
    check({22'h0, fault_oe, fault_o}, 24'h0);
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    t_single();
    t_chain();
    t_short();
    t_ignored();
    t_fault();
    conclude();
  end
  // About 7x the 23 us the scenarios need
  initial begin
    #160000;
    err_count++;
    conclude();
  end
endmodule
